// *** src/cefm_cfg.svh ***
// Register map, field positions, reset values and the pulse timing for the event/mask block
`ifndef CEFM_CFG_SVH
`define CEFM_CFG_SVH

`define CEFM_ADDR_CHG_EVT   8'h21
`define CEFM_ADDR_FLT_EVT   8'h22
`define CEFM_ADDR_MASK_A    8'h23
`define CEFM_ADDR_MASK_B    8'h24
`define CEFM_RESET_VAL      8'h00
`define CEFM_CHG_EVT_USED   8'h09
`define CEFM_FLT_EVT_USED   8'hF9
`define CEFM_MASK_B_USED    8'h09
`define CEFM_BIT_CHG        3
`define CEFM_BIT_SUPPLY     0
`define CEFM_BIT_VIN_FLT    7
`define CEFM_BIT_BAT_FLT    6
`define CEFM_BIT_SYS_FLT    5
`define CEFM_BIT_BST_FLT    4
`define CEFM_BIT_DIE_THERMAL_SHUTDOWN      3
`define CEFM_BIT_TZONE      0
`define CEFM_BIT_ADC_DONE   6
`define CEFM_BIT_DIE_THERMAL_REGULATION       5
`define CEFM_BIT_VSYS       4
`define CEFM_BIT_ILOOP      3
`define CEFM_BIT_VLOOP      2
`define CEFM_BIT_TIMER      1
`define CEFM_BIT_WDOG       0
`define CEFM_INT_PULSE_NS   256
`define CEFM_CLK_NS         4
`define CEFM_INT_PULSE_CYC  ((`CEFM_INT_PULSE_NS + `CEFM_CLK_NS - 1) / `CEFM_CLK_NS)

`endif

// *** src/cefm_pkg.sv ***
// Types shared by the event/mask block
`default_nettype none
package cefm_pkg;
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cefm_reg_req_type;
   typedef struct packed {
      logic       charge_status_changed;
      logic       input_supply_changed;
      logic       input_overvolt_sleep_enter;
      logic       battery_fault_enter;
      logic       system_rail_fault_stop;
      logic       boost_output_fault_stop;
      logic       die_thermal_shutdown;
      logic       temp_zone_changed;
      logic       conversion_done;
      logic       single_conversion_mode;
      logic       die_thermal_regulation;
      logic       minimum_system_voltage;
      logic       current_loop_active;
      logic       voltage_loop_active;
      logic       charge_timer_expired;
      logic       watchdog_expired;
   } cefm_evt_type;
   typedef enum logic [0:0] {
      CEFM_IDLE  = 1'b0,
      CEFM_PULSE = 1'b1
   } cefm_pulse_state_type;
endpackage
`default_nettype wire

// *** src/cefm_edge.sv ***
// Rising and falling edge detector bank for level event sources
`default_nettype none
module cefm_edge #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // Levels and their edges
   input  wire logic [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   typedef struct packed {
      logic [WIDTH-1:0] prev;
   } cefm_edge_st_type;
   cefm_edge_st_type st_q;
   cefm_edge_st_type st_d;

   always_comb begin
      st_d.prev = level;
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_edge
      assign rise[i] = level[i] & ~st_q.prev[i];
      assign fall[i] = ~level[i] & st_q.prev[i];
   end
endmodule // cefm_edge
`default_nettype wire

// *** src/cefm_pulse.sv ***
// Stretches an interrupt request into a fixed-length active-low pulse
`include "cefm_cfg.svh"
`default_nettype none
module cefm_pulse #(
   parameter int PULSE_CYC = `CEFM_INT_PULSE_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // Request and pin
   input  wire logic req,
   output logic      int_b
);
   import cefm_pkg::*;
   typedef struct packed {
      cefm_pulse_state_type state;
      logic [15:0]          cnt;
      logic                 int_b;
   } cefm_pulse_st_type;
   cefm_pulse_st_type st_q;
   cefm_pulse_st_type st_d;

   always_comb begin
      st_d = st_q;
      case (st_q.state)
         CEFM_IDLE: begin
            st_d.int_b = 1'b1;
            if (req) begin
               st_d.state = CEFM_PULSE;
               st_d.cnt   = 16'(PULSE_CYC - 1);
               st_d.int_b = 1'b0;
            end
         end
         CEFM_PULSE: begin
            if (st_q.cnt == 16'h0000) begin
               st_d.state = CEFM_IDLE;
               st_d.int_b = 1'b1;
            end else begin
               st_d.cnt = st_q.cnt - 16'h0001;
            end
         end
         default: begin
            st_d.state = CEFM_IDLE;
            st_d.int_b = 1'b1;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '{state: CEFM_IDLE, cnt: 16'h0000, int_b: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end
   assign int_b = st_q.int_b;
endmodule // cefm_pulse
`default_nettype wire

// *** src/cefm_top.sv ***
// Event flag latching, read-to-clear and interrupt masking for the charger
`include "cefm_cfg.svh"
`default_nettype none
module cefm_top #(
   parameter int PULSE_CYC = `CEFM_INT_PULSE_CYC
) (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    rst_b,
   // Register access from the serial interface
   input  wire cefm_pkg::cefm_reg_req_type reg_req,
   input  wire logic                    reg_reset_cmd,
   output logic      [7:0]              reg_rdata,
   // Event sources from the charger core
   input  wire cefm_pkg::cefm_evt_type  evt,
   // Interrupt pin
   output logic                         int_b
);
   import cefm_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] chg_flags;
      logic [7:0] flt_flags;
      logic [7:0] mask_a;
      logic [7:0] mask_b;
      logic [7:0] rdata;
   } cefm_top_st_type;
   cefm_top_st_type st_q;
   cefm_top_st_type st_d;

   logic [5:0] lvl_rise;
   logic [5:0] lvl_fall;
   logic [7:0] chg_set;
   logic [7:0] flt_set;
   logic       int_req;

   // ----------------------------------------------------------------
   // Edge detection of level sources
   // ----------------------------------------------------------------
   cefm_edge #(
      .WIDTH (6)
   ) u_edge (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .level   ({evt.die_thermal_shutdown, evt.die_thermal_regulation,
                 evt.minimum_system_voltage, evt.current_loop_active,
                 evt.voltage_loop_active, evt.charge_timer_expired}),
      .rise    (lvl_rise),
      .fall    (lvl_fall)
   );

   // ----------------------------------------------------------------
   // Event set vectors
   // ----------------------------------------------------------------
   always_comb begin
      chg_set = 8'h00;
      chg_set[`CEFM_BIT_CHG]    = evt.charge_status_changed;
      chg_set[`CEFM_BIT_SUPPLY] = evt.input_supply_changed;
      flt_set = 8'h00;
      flt_set[`CEFM_BIT_VIN_FLT] = evt.input_overvolt_sleep_enter;
      flt_set[`CEFM_BIT_BAT_FLT] = evt.battery_fault_enter;
      flt_set[`CEFM_BIT_SYS_FLT] = evt.system_rail_fault_stop;
      flt_set[`CEFM_BIT_BST_FLT] = evt.boost_output_fault_stop;
      flt_set[`CEFM_BIT_DIE_THERMAL_SHUTDOWN]   = lvl_rise[5];
      flt_set[`CEFM_BIT_TZONE]   = evt.temp_zone_changed;
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   always_comb begin
      int_req = 1'b0;
      if (evt.conversion_done && evt.single_conversion_mode
          && !st_q.mask_a[`CEFM_BIT_ADC_DONE]) begin
         int_req = 1'b1;
      end
      if (lvl_rise[4] && !st_q.mask_a[`CEFM_BIT_DIE_THERMAL_REGULATION]) begin
         int_req = 1'b1;
      end
      if ((lvl_rise[3] || lvl_fall[3])
          && !st_q.mask_a[`CEFM_BIT_VSYS]) begin
         int_req = 1'b1;
      end
      if (lvl_rise[2] && !st_q.mask_a[`CEFM_BIT_ILOOP]) begin
         int_req = 1'b1;
      end
      if (lvl_rise[1] && !st_q.mask_a[`CEFM_BIT_VLOOP]) begin
         int_req = 1'b1;
      end
      if (lvl_rise[0] && !st_q.mask_a[`CEFM_BIT_TIMER]) begin
         int_req = 1'b1;
      end
      if (evt.watchdog_expired && !st_q.mask_a[`CEFM_BIT_WDOG]) begin
         int_req = 1'b1;
      end
      if (chg_set[`CEFM_BIT_CHG] && !st_q.mask_b[`CEFM_BIT_CHG]) begin
         int_req = 1'b1;
      end
      if (chg_set[`CEFM_BIT_SUPPLY]
          && !st_q.mask_b[`CEFM_BIT_SUPPLY]) begin
         int_req = 1'b1;
      end
      if (|flt_set) begin
         int_req = 1'b1;
      end
   end

   cefm_pulse #(
      .PULSE_CYC (PULSE_CYC)
   ) u_pulse (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .req     (int_req),
      .int_b   (int_b)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rdata = `CEFM_RESET_VAL;
      if (reg_req.rd_en) begin
         case (reg_req.addr)
            `CEFM_ADDR_CHG_EVT: begin
               st_d.rdata     = st_q.chg_flags;
               st_d.chg_flags = `CEFM_RESET_VAL;
            end
            `CEFM_ADDR_FLT_EVT: begin
               st_d.rdata     = st_q.flt_flags;
               st_d.flt_flags = `CEFM_RESET_VAL;
            end
            `CEFM_ADDR_MASK_A: st_d.rdata = st_q.mask_a;
            `CEFM_ADDR_MASK_B: st_d.rdata = st_q.mask_b;
            default:           st_d.rdata = `CEFM_RESET_VAL;
         endcase
      end
      // Set wins over read clear
      st_d.chg_flags = (st_d.chg_flags | chg_set) & `CEFM_CHG_EVT_USED;
      st_d.flt_flags = (st_d.flt_flags | flt_set) & `CEFM_FLT_EVT_USED;
      if (reg_req.wr_en) begin
         case (reg_req.addr)
            `CEFM_ADDR_MASK_A: st_d.mask_a = reg_req.wdata;
            `CEFM_ADDR_MASK_B: st_d.mask_b = reg_req.wdata & `CEFM_MASK_B_USED;
            default: begin
            end
         endcase
      end
      if (reg_reset_cmd) begin
         st_d.mask_a = `CEFM_RESET_VAL;
         st_d.mask_b = `CEFM_RESET_VAL;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
endmodule // cefm_top
`default_nettype wire

// *** testbench/cefm_monitor.sv ***
// Port assertions for the event/mask block
`default_nettype none
module cefm_monitor #(
   parameter int PULSE_CYC = 4
) (
   // Clock and reset
   input wire logic                       ref_clk,
   input wire logic                       rst_b,
   // Register side
   input wire cefm_pkg::cefm_reg_req_type reg_req,
   input wire logic                       reg_reset_cmd,
   input wire logic [7:0]                 reg_rdata,
   // Events and pin
   input wire cefm_pkg::cefm_evt_type     evt,
   input wire logic                       int_b
);
   timeunit 1ns;
   timeprecision 1ps;
   import cefm_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] mask_a_q;
   logic [7:0] mask_b_q;
   logic       hi_q;
   int         low_q;
   logic       idle;
   assign idle = int_b && hi_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_a_q <= 8'h00;
         mask_b_q <= 8'h00;
         hi_q     <= 1'b1;
         low_q    <= 0;
      end else begin
         hi_q  <= int_b;
         low_q <= int_b ? 0 : low_q + 1;
         if (reg_reset_cmd) begin
            mask_a_q <= 8'h00;
            mask_b_q <= 8'h00;
         end else if (reg_req.wr_en && reg_req.addr == 8'h23) begin
            mask_a_q <= reg_req.wdata;
         end else if (reg_req.wr_en && reg_req.addr == 8'h24) begin
            mask_b_q <= reg_req.wdata & 8'h09;
         end
      end
   end
   sequence s_rd(logic [7:0] a);
      reg_req.rd_en && reg_req.addr == a;
   endsequence
   sequence s_quiet_rd;
      reg_req.rd_en && reg_req.addr == 8'h22 && evt[13:8] == 6'h00;
   endsequence
   a_chg_rsvd: assert property (s_rd(8'h21) |=> (reg_rdata & 8'hF6) == 8'h00)
      else $error("reserved charger event bits set");
   a_flt_rsvd: assert property (s_rd(8'h22) |=> reg_rdata[2:1] == 2'b00)
      else $error("reserved fault event bits set");
   a_mask_a_read: assert property (s_rd(8'h23) |=> reg_rdata == $past(mask_a_q))
      else $error("mask a read mismatch");
   a_mask_b_read: assert property (s_rd(8'h24) |=> reg_rdata == $past(mask_b_q))
      else $error("mask b read mismatch");
   a_flt_latch: assert property (evt.battery_fault_enter ##1 reg_req.addr != 8'h22
      ##1 s_rd(8'h22) |=> reg_rdata[6])
      else $error("battery fault flag not latched");
   a_read_clear: assert property (s_quiet_rd ##1 evt[13:8] == 6'h00 ##1 s_rd(8'h22)
      |=> reg_rdata == 8'h00)
      else $error("fault flags not cleared by read");
   a_wdog_int: assert property (evt.watchdog_expired && !mask_a_q[0] && idle |=> !int_b)
      else $error("watchdog interrupt missing");
   a_chg_int: assert property (evt.charge_status_changed && !mask_b_q[3] && idle |=> !int_b)
      else $error("charge status interrupt missing");
   a_zone_int: assert property (evt.temp_zone_changed && idle |=> !int_b)
      else $error("temperature zone interrupt missing");
   a_pulse_len: assert property ($rose(int_b) |-> low_q == PULSE_CYC)
      else $error("interrupt pulse length wrong");
endmodule // cefm_monitor
bind cefm_top cefm_monitor #(.PULSE_CYC(PULSE_CYC)) mon_u (.ref_clk(ref_clk), .rst_b(rst_b),
   .reg_req(reg_req), .reg_reset_cmd(reg_reset_cmd), .reg_rdata(reg_rdata), .evt(evt),
   .int_b(int_b));
`default_nettype wire

// *** testbench/cefm_host.sv ***
// Host model making register accesses
`default_nettype none
module cefm_host (
   // Clock
   input wire logic                      ref_clk,
   // Register side
   output var cefm_pkg::cefm_reg_req_type reg_req,
   input wire logic [7:0]                reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import cefm_pkg::*;
   initial reg_req = '0;
   // Reads flags after interrupts, sets masks before events
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge ref_clk);
      #1;
      reg_req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      q = reg_rdata;
      reg_req = '0;
   endtask
endmodule // cefm_host
`default_nettype wire

// *** testbench/cefm_top_test.sv ***
// Self-checking bench for the event/mask block
`default_nettype none
module cefm_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cefm_pkg::*;
   localparam int PC = 4;
   logic             ref_clk = 1'b0;
   logic             rst_b = 1'b0;
   logic             reg_reset_cmd = 1'b0;
   logic [15:0]      ev = 16'h0040;
   logic [15:0]      f;
   logic [7:0]       q, ma, mb;
   wire [7:0]        rdata;
   wire logic        int_b;
   wire cefm_reg_req_type reg_req;
   int               n_fail = 0, samples_checked = 0, cyc = 0;
   integer           seed = 32'h6DBE;
   always #2 ref_clk = ~ref_clk;
   cefm_top #(.PULSE_CYC(PC)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req),
      .reg_reset_cmd(reg_reset_cmd), .reg_rdata(rdata), .evt(cefm_evt_type'(ev)), .int_b(int_b));
   cefm_host host_u (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(rdata));
   task automatic chk(input string n, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic fire(int i);
      @(posedge ref_clk);
      #1;
      ev[i] = 1'b1;
      @(posedge ref_clk);
      #1;
      ev[i] = 1'b0;
   endtask
   // Address and bit latched by each flag-setting event input (15 down to 8)
   function automatic logic [15:0] flag_of(int i);
      case (i)
         15: return 16'h2108;
         14: return 16'h2101;
         13: return 16'h2280;
         12: return 16'h2240;
         11: return 16'h2220;
         10: return 16'h2210;
         9: return 16'h2208;
         default: return 16'h2201;
      endcase
   endfunction
   function automatic logic int_of(int i);
      case (i)
         15: return !mb[3];
         14: return !mb[0];
         7: return !ma[6];
         default: return (i > 7) || !ma[i];
      endcase
   endfunction
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      #1;
      rst_b = 1'b1;
      for (int a = 32'h20; a < 32'h26; a++) begin
         host_u.xfer(1'b0, a[7:0], 8'h00, q);
         chk("reset value", 8'h00, q);
         host_u.xfer(1'b1, a[7:0], 8'hFF, q);
         host_u.xfer(1'b0, a[7:0], 8'h00, q);
         chk("after write", a == 32'h23 ? 8'hFF : a == 32'h24 ? 8'h09 : 8'h00, q);
      end
      @(posedge ref_clk);
      #1;
      reg_reset_cmd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_reset_cmd = 1'b0;
      host_u.xfer(1'b0, 8'h24, 8'h00, q);
      chk("mask b after reset cmd", 8'h00, q);
      host_u.xfer(1'b0, 8'h23, 8'h00, q);
      chk("mask a after reset cmd", 8'h00, q);
      for (int i = 15; i > 7; i--) begin
         f = flag_of(i);
         fire(i);
         host_u.xfer(1'b0, f[15:8], 8'h00, q);
         chk("event flag", f[7:0], q);
         host_u.xfer(1'b0, f[15:8], 8'h00, q);
         chk("flag after read", 8'h00, q);
      end
      for (int r = 0; r < 4; r++) begin
         ma = r == 0 ? 8'h00 : r == 1 ? 8'hFF : 8'($random(seed));
         mb = r == 0 ? 8'h00 : r == 1 ? 8'hFF : 8'($random(seed));
         host_u.xfer(1'b1, 8'h23, ma, q);
         host_u.xfer(1'b1, 8'h24, mb, q);
         host_u.xfer(1'b0, 8'h24, 8'h00, q);
         chk("mask b", mb & 8'h09, q);
         for (int i = 0; i < 16; i++) begin
            if (i != 6) begin
               repeat (PC + 3) @(posedge ref_clk);
               fire(i);
               chk("int pin", {7'h00, !int_of(i)}, {7'h00, int_b});
            end
         end
         repeat (PC + 3) @(posedge ref_clk);
         #1;
         ev[4] = 1'b1;
         repeat (PC + 3) @(posedge ref_clk);
         #1;
         ev[4] = 1'b0;
         @(posedge ref_clk);
         #1;
         chk("int on exit", {7'h00, ma[4]}, {7'h00, int_b});
      end
      // Conversion done outside single conversion mode never interrupts
      host_u.xfer(1'b1, 8'h23, 8'h00, q);
      repeat (PC + 3) @(posedge ref_clk);
      #1;
      ev[6] = 1'b0;
      fire(7);
      chk("int in continuous mode", 8'h01, {7'h00, int_b});
      summarize();
   end
endmodule // cefm_top_test
`default_nettype wire
